// ---- verilog/obcd_pkg.sv ----
// Purpose: Shared constants for the option byte configuration decoder
// Assumes: 32-bit classic Wishbone register access, byte-wide option data
// Notes: Offsets are byte addresses of aligned words
package obcd_pkg;
    localparam logic [7:0] ADDR_OPT0 = 8'h00;
    localparam logic [7:0] ADDR_OPT1 = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;

    localparam logic [7:0] OPT0_RST = 8'hf4;
    localparam logic [7:0] OPT1_RST = 8'hef;
    localparam logic [7:0] OPT_ERASED = 8'hff;

    localparam int B0_RSVD = 7;
    localparam int B0_PKG = 6;
    localparam int B0_CLK_HI = 5;
    localparam int B0_CLK_LO = 4;
    localparam int B0_SEC_HI = 3;
    localparam int B0_SEC_LO = 2;
    localparam int B0_RDP = 1;
    localparam int B0_WRP = 0;

    localparam int B1_PLL_MUL = 7;
    localparam int B1_PLL_OFF = 6;
    localparam int B1_PLL32_OFF = 5;
    localparam int B1_OSC = 4;
    localparam int B1_LVD_HI = 3;
    localparam int B1_LVD_LO = 2;
    localparam int B1_WDG_SW = 1;
    localparam int B1_WDG_HALT = 0;

    localparam logic [1:0] CLK_RESONATOR = 2'h0;
    localparam logic [1:0] CLK_EXT_PB4 = 2'h1;
    localparam logic [1:0] CLK_RESERVED = 2'h2;
    localparam logic [1:0] CLK_EXT_PC0 = 2'h3;

    localparam logic [12:0] SECTOR0_SIZE_LO_MIN_BYTES = 13'h0200;

    localparam int CMD_ERASE = 0;
    localparam int ST_PROG = 0;
    localparam int ST_WP_LOCK = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_RDP = 4;

    localparam int MASS_ERASE_CYCLES = 16;

    typedef enum logic [1:0] {
        OBCD_IDLE = 2'b00,
        OBCD_MASS = 2'b01,
        OBCD_OPTER = 2'b10
    } obcd_state_e;
endpackage

// ---- verilog/obcd_optstore.sv ----
// Purpose: Small store holding the option bytes
// Assumes: One write port, whole-store erase, registered read data
// Notes: Reset loads the delivered contents
`timescale 1ns/1ps
module obcd_optstore #(
    parameter int W = 8,
    parameter int N = 2,
    parameter logic [N*W-1:0] RST_VALS = '0,
    parameter logic [W-1:0] ERASE_VAL = '1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [$clog2(N)-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic erase_all,
    input wire logic [$clog2(N)-1:0] rd_addr,
    output logic [W-1:0] rd_data,
    output logic [N*W-1:0] bytes
);
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_entry
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    bytes[gi*W +: W] <= RST_VALS[gi*W +: W];
                else if (erase_all)
                    bytes[gi*W +: W] <= ERASE_VAL;
                else if (wr_en && (wr_addr == gi))
                    bytes[gi*W +: W] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rd_data <= '0;
        else
            rd_data <= bytes[rd_addr*W +: W];
    end
endmodule

// ---- verilog/obcd_top.sv ----
// Purpose: Option byte store, access gate and decoder of hardware settings
// Assumes: Programming mode arrives on an asynchronous pin; one clock domain
// Notes: Decoded outputs are refreshed every cycle from the stored bytes
`timescale 1ns/1ps
module obcd_top
#(
    parameter int ERASE_CYCLES = obcd_pkg::MASS_ERASE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic prog_mode_pin,
    output logic package_select,
    output logic [1:0] clock_source_field,
    output logic int_rc_selected,
    output logic resonator_selected,
    output logic ext_clock_on_port_b_pin4,
    output logic ext_clock_on_port_c_pin0,
    output logic port_c_enable,
    output logic [12:0] sector0_bytes,
    output logic readout_protect,
    output logic flash_write_protect,
    output logic flash_extract_block,
    output logic flash_write_block,
    output logic mass_erase_active,
    output logic pll_multiplier_select,
    output logic pll_disable,
    output logic pll32_disable,
    output logic osc_type,
    output logic lowvolt_detect_hi,
    output logic lowvolt_detect_lo,
    output logic watchdog_soft_enable,
    output logic watchdog_halt_ctrl
);
    import obcd_pkg::*;
    localparam int CW = $clog2(ERASE_CYCLES) + 1;
    logic s1_q, s2_q, s3_q, prog_q, ack_q, rd_opt_q, first_q, refused_q;
    logic [31:0] dat_q;
    logic [CW-1:0] cnt_q;
    obcd_state_e state_q;
    logic [7:0] opt0, opt1, mem_rd;
    logic req, wr_fire, a_opt0, a_opt1, a_cmd, a_stat, mem_we, erase_go, refuse, mem_erase;

    // Pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            prog_q <= 1'b0;
        end
        else
        begin
            s1_q <= prog_mode_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                prog_q <= s3_q;
        end
    end
    assign req = wb_cyc_i && wb_stb_i;
    assign a_opt0 = (wb_adr_i == ADDR_OPT0);
    assign a_opt1 = (wb_adr_i == ADDR_OPT1);
    assign a_cmd = (wb_adr_i == ADDR_CMD);
    assign a_stat = (wb_adr_i == ADDR_STAT);
    // A write takes effect at the edge where the master sees ack
    assign wr_fire = req && wb_we_i && ack_q && wb_sel_i[0];
    // Option bytes move only in programming mode, idle, and not locked
    assign mem_we = wr_fire && prog_q && (state_q == OBCD_IDLE) && (a_opt0 || a_opt1)
                    && !opt0[B0_RDP] && !(a_opt0 && opt0[B0_WRP]);
    assign erase_go = wr_fire && prog_q && (state_q == OBCD_IDLE) && a_cmd
                      && wb_dat_i[CMD_ERASE] && !opt0[B0_WRP];
    assign refuse = wr_fire && (a_opt0 || a_opt1 || (a_cmd && wb_dat_i[CMD_ERASE]))
                    && !mem_we && !erase_go;
    assign mem_erase = (state_q == OBCD_OPTER);
    // Stored value is taken as written; bit 7 of byte 0 is the programmer's to keep at one
    obcd_optstore #(
        .W(8),
        .N(2),
        .RST_VALS({OPT1_RST, OPT0_RST}),
        .ERASE_VAL(OPT_ERASED)
    ) u_store (
        .mclk(mclk),
        .rst(rst),
        .wr_en(mem_we),
        .wr_addr(wb_adr_i[2]),
        .wr_data(wb_dat_i[7:0]),
        .erase_all(mem_erase),
        .rd_addr(wb_adr_i[2]),
        .rd_data(mem_rd),
        .bytes({opt1, opt0})
    );
    // Wishbone answer one cycle after the request, dropped the cycle after
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            rd_opt_q <= 1'b0;
            dat_q <= 32'h0;
        end
        else
        begin
            ack_q <= req && !ack_q;
            if (req && !ack_q)
            begin
                rd_opt_q <= prog_q && (a_opt0 || a_opt1);
                dat_q <= 32'h0;
                if (a_stat)
                begin
                    dat_q[ST_PROG] <= prog_q;
                    dat_q[ST_WP_LOCK] <= opt0[B0_WRP];
                    dat_q[ST_BUSY] <= (state_q != OBCD_IDLE);
                    dat_q[ST_REFUSED] <= refused_q;
                    dat_q[ST_RDP] <= opt0[B0_RDP];
                end
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_opt_q ? {24'h0, mem_rd} : dat_q;
    // Sticky refusal flag: a new refusal wins over a clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            refused_q <= 1'b0;
        else if (refuse)
            refused_q <= 1'b1;
        else if (wr_fire && a_stat && wb_dat_i[ST_REFUSED])
            refused_q <= 1'b0;
    end
    // Erase sequencer: whole memory goes first when read-out protected
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= OBCD_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                OBCD_IDLE:
                begin
                    if (erase_go)
                    begin
                        state_q <= opt0[B0_RDP] ? OBCD_MASS : OBCD_OPTER;
                        cnt_q <= CW'(ERASE_CYCLES - 1);
                    end
                end
                OBCD_MASS:
                begin
                    if (cnt_q == '0)
                        state_q <= OBCD_OPTER;
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                OBCD_OPTER:
                    state_q <= OBCD_IDLE;
                default:
                    state_q <= OBCD_IDLE;
            endcase
        end
    end
    assign mass_erase_active = (state_q == OBCD_MASS);
    // Decoded settings
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            package_select <= 1'b0;
            clock_source_field <= 2'h0;
            int_rc_selected <= 1'b1;
            resonator_selected <= 1'b0;
            ext_clock_on_port_b_pin4 <= 1'b0;
            ext_clock_on_port_c_pin0 <= 1'b0;
            port_c_enable <= 1'b1;
            sector0_bytes <= SECTOR0_SIZE_LO_MIN_BYTES;
            readout_protect <= 1'b0;
            flash_write_protect <= 1'b0;
            flash_extract_block <= 1'b0;
            flash_write_block <= 1'b0;
        end
        else
        begin
            package_select <= opt0[B0_PKG];
            clock_source_field <= opt0[B0_CLK_HI:B0_CLK_LO];
            int_rc_selected <= !opt1[B1_OSC];
            resonator_selected <= opt1[B1_OSC] && (opt0[B0_CLK_HI:B0_CLK_LO] == CLK_RESONATOR);
            ext_clock_on_port_b_pin4 <= opt1[B1_OSC] && (opt0[B0_CLK_HI:B0_CLK_LO] == CLK_EXT_PB4);
            ext_clock_on_port_c_pin0 <= opt1[B1_OSC] && (opt0[B0_CLK_HI:B0_CLK_LO] == CLK_EXT_PC0);
            port_c_enable <= !(opt1[B1_OSC] && (opt0[B0_CLK_HI:B0_CLK_LO] == CLK_EXT_PC0));
            sector0_bytes <= SECTOR0_SIZE_LO_MIN_BYTES << opt0[B0_SEC_HI:B0_SEC_LO];
            readout_protect <= opt0[B0_RDP];
            flash_write_protect <= opt0[B0_WRP];
            flash_extract_block <= opt0[B0_RDP];
            flash_write_block <= opt0[B0_RDP] || opt0[B0_WRP];
        end
    end
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pll_multiplier_select <= 1'b1;
            pll_disable <= 1'b1;
            pll32_disable <= 1'b1;
            osc_type <= 1'b0;
            lowvolt_detect_hi <= 1'b1;
            lowvolt_detect_lo <= 1'b1;
            watchdog_soft_enable <= 1'b1;
            watchdog_halt_ctrl <= 1'b1;
        end
        else
        begin
            pll_multiplier_select <= opt1[B1_PLL_MUL];
            pll_disable <= opt1[B1_PLL_OFF];
            pll32_disable <= opt1[B1_PLL32_OFF];
            osc_type <= opt1[B1_OSC];
            lowvolt_detect_hi <= opt1[B1_LVD_HI];
            lowvolt_detect_lo <= opt1[B1_LVD_LO];
            watchdog_soft_enable <= opt1[B1_WDG_SW];
            watchdog_halt_ctrl <= opt1[B1_WDG_HALT];
        end
    end
    // First cycle after reset, for checking
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end
    sequence s_erase_rdp;
        erase_go && opt0[B0_RDP];
    endsequence
    sequence s_mass_run;
        mass_erase_active [*8];
    endsequence
    a_ack_single: assert property (@(posedge mclk) disable iff (rst) ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");
    a_noprog_nowrite: assert property (@(posedge mclk) disable iff (rst)
        (wr_fire && !prog_q && state_q == OBCD_IDLE) |=> ($stable(opt0) && $stable(opt1)))
        else $error("option byte changed outside programming mode");
    a_pkg_decode: assert property (@(posedge mclk) disable iff (rst)
        !first_q |-> package_select == $past(opt0[B0_PKG]))
        else $error("package select mismatch");
    a_rc_no_ext: assert property (@(posedge mclk) disable iff (rst)
        (!first_q && !$past(opt1[B1_OSC])) |-> (!resonator_selected && port_c_enable && int_rc_selected))
        else $error("clock field acted under internal RC");
    a_pc0_portc: assert property (@(posedge mclk) disable iff (rst)
        (!first_q && $past(opt1[B1_OSC]) && $past(opt0[B0_CLK_HI:B0_CLK_LO]) == CLK_EXT_PC0)
        |-> (ext_clock_on_port_c_pin0 && !port_c_enable && !ext_clock_on_port_b_pin4))
        else $error("port C pin 0 clock decode wrong");
    a_sector_size: assert property (@(posedge mclk) disable iff (rst)
        ($past(opt0[B0_SEC_HI:B0_SEC_LO]) == 2'h3 && !first_q) |-> sector0_bytes == 13'h1000)
        else $error("sector 0 size wrong");
    a_rdp_blocks: assert property (@(posedge mclk) disable iff (rst)
        readout_protect |-> (flash_extract_block && flash_write_block))
        else $error("read-out protection not blocking");
    a_mass_first: assert property (@(posedge mclk) disable iff (rst)
        s_erase_rdp |=> s_mass_run ##[1:40] (opt0 == OPT_ERASED && opt1 == OPT_ERASED))
        else $error("mass erase did not precede option erase");
    a_wp_refuse: assert property (@(posedge mclk) disable iff (rst)
        opt0[B0_WRP] |=> (opt0[B0_WRP] && state_q == OBCD_IDLE && $stable(opt0)))
        else $error("write-protected option byte changed");
    a_reset_vals: assert property (@(posedge mclk) disable iff (rst)
        first_q |-> (opt0 == OPT0_RST && opt1 == OPT1_RST))
        else $error("reset contents wrong");
    a_byte1_map: assert property (@(posedge mclk) disable iff (rst)
        !first_q |-> {pll_multiplier_select, pll_disable, pll32_disable, osc_type, lowvolt_detect_hi,
                      lowvolt_detect_lo, watchdog_soft_enable, watchdog_halt_ctrl} == $past(opt1))
        else $error("byte 1 outputs do not follow the stored byte");
endmodule

// ---- testbench/obcd_programmer.sv ----
// Purpose: Programming tool model driving the option store over classic Wishbone
// Assumes: One single cycle at a time, programming mode on its own pin
// Notes: Keeps the tool's own duties on the contents of byte 0
`timescale 1ns/1ps
module obcd_programmer (
    input wire logic mclk,
    input wire logic rst,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat_w,
    input wire logic [31:0] dat_r,
    input wire logic ack,
    output logic prog_mode
);
    import obcd_pkg::*;
    logic osc_q = 1'b0;
    initial
    begin
        {cyc, stb, we, adr, sel, dat_w, prog_mode} = '0;
    end
    // Internal RC comes back after every reset
    always @(posedge rst)
        osc_q = 1'b0;
    task automatic cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat_w <= d;
        do
            @(posedge mclk);
        while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        logic [31:0] q;
        v = d;
        if (a == ADDR_OPT0)
            v[B0_RSVD] = 1'b1;
        if (a == ADDR_OPT1)
            osc_q = v[B1_OSC];
        if (a == ADDR_OPT0 && !osc_q)
            v[5:4] = 2'h3;
        cycle(1'b1, a, {24'h0, v}, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        cycle(1'b0, a, 32'h0, q);
    endtask
    task automatic set_mode(input logic v);
        @(posedge mclk);
        prog_mode <= v;
    endtask
endmodule

// ---- testbench/obcd_top_tb.sv ----
// Purpose: Self-checking bench for the option byte decoder
// Assumes: Shortened whole-memory erase of eight cycles
// Notes: Each scenario restarts from the delivered contents where it needs to
`timescale 1ns/1ps
module obcd_top_tb;
    import obcd_pkg::*;
    `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
        $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
    localparam int ERASE_N = 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] k;
    logic [31:0] q;
    wire cyc, stb, we, ack, pmode;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] dat_w, dat_r;
    wire pkg, rc, reso, pb4, pc0, pce, rdp, wp, xblk, wblk, mea;
    wire [1:0] csf;
    wire [12:0] sec;
    wire [7:0] b1;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    obcd_top #(.ERASE_CYCLES(ERASE_N)) i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .prog_mode_pin(pmode), .package_select(pkg), .clock_source_field(csf), .int_rc_selected(rc),
        .resonator_selected(reso), .ext_clock_on_port_b_pin4(pb4), .ext_clock_on_port_c_pin0(pc0),
        .port_c_enable(pce), .sector0_bytes(sec), .readout_protect(rdp), .flash_write_protect(wp),
        .flash_extract_block(xblk), .flash_write_block(wblk), .mass_erase_active(mea),
        .pll_multiplier_select(b1[7]), .pll_disable(b1[6]), .pll32_disable(b1[5]), .osc_type(b1[4]),
        .lowvolt_detect_hi(b1[3]), .lowvolt_detect_lo(b1[2]), .watchdog_soft_enable(b1[1]),
        .watchdog_halt_ctrl(b1[0]));
    obcd_programmer i_prog (.mclk(mclk), .rst(rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .prog_mode(pmode));
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic do_reset();
        rst <= 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    // Decoded outputs trail the store by one edge
    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask
    initial
    begin
        do_reset();
        settle();
        `CHK({pkg, csf, rc, pce, sec}, {1'b1, 2'h3, 1'b1, 1'b1, 13'h0400})
        `CHK({reso, pb4, pc0, pce}, 4'h1)
        `CHK(b1, OPT1_RST)
        i_prog.rd(ADDR_OPT0, q);
        `CHK(q, 32'h0)
        i_prog.wr(ADDR_OPT0, 8'h80);
        settle();
        `CHK({pkg, csf, sec}, {1'b1, 2'h3, 13'h0400})
        i_prog.set_mode(1'b1);
        repeat (6) @(posedge mclk);
        i_prog.rd(ADDR_OPT0, q);
        `CHK(q, {24'h0, OPT0_RST})
        i_prog.rd(ADDR_OPT1, q);
        `CHK(q, {24'h0, OPT1_RST})
        i_prog.rd(ADDR_STAT, q);
        `CHK(q[4:0], 5'h09)
        i_prog.wr(ADDR_STAT, 8'h08);
        i_prog.rd(ADDR_STAT, q);
        `CHK(q[3], 1'b0)
        i_prog.rd(8'h40, q);
        `CHK(q, 32'h0)
        i_prog.wr(ADDR_OPT1, 8'h1a);
        settle();
        `CHK(b1, 8'h1a)
        for (int c = 0; c < 4; c++)
        begin
            k = c[1:0];
            i_prog.wr(ADDR_OPT0, {1'b1, k[0], k, k, 2'b00});
            settle();
            `CHK(pkg, k[0])
            `CHK(csf, k)
            `CHK(rc, 1'b0)
            `CHK({reso, pb4, pc0, pce}, {k == 2'h0, k == 2'h1, k == 2'h3, k != 2'h3})
            `CHK(sec, 13'h0200 << k)
            `CHK({wp, rdp, wblk, xblk}, 4'h0)
        end
        i_prog.wr(ADDR_OPT0, 8'h85);
        settle();
        `CHK({wp, wblk, rdp, xblk}, 4'hc)
        i_prog.rd(ADDR_STAT, q);
        `CHK(q[3], 1'b0)
        i_prog.wr(ADDR_OPT0, 8'hf4);
        i_prog.rd(ADDR_STAT, q);
        `CHK(q[3:1], 3'b101)
        i_prog.wr(ADDR_STAT, 8'h08);
        i_prog.wr(ADDR_CMD, 8'h01);
        settle();
        `CHK(mea, 1'b0)
        i_prog.rd(ADDR_OPT0, q);
        `CHK(q, 32'h85)
        i_prog.rd(ADDR_STAT, q);
        `CHK(q[3:1], 3'b101)
        do_reset();
        i_prog.wr(ADDR_OPT0, 8'hf6);
        settle();
        `CHK({rdp, xblk, wblk, wp}, 4'he)
        `CHK(csf, 2'h3)
        i_prog.rd(ADDR_STAT, q);
        `CHK(q[4], 1'b1)
        i_prog.wr(ADDR_OPT1, 8'h00);
        i_prog.rd(ADDR_OPT1, q);
        `CHK(q, {24'h0, OPT1_RST})
        i_prog.wr(ADDR_CMD, 8'h01);
        n = 0;
        repeat (40)
        begin
            @(negedge mclk);
            if (mea === 1'b1)
                n++;
        end
        `CHK(n, ERASE_N)
        i_prog.rd(ADDR_OPT0, q);
        `CHK(q, {24'h0, OPT_ERASED})
        i_prog.rd(ADDR_OPT1, q);
        `CHK(q, {24'h0, OPT_ERASED})
        end_of_test();
    end
endmodule
